// ===== rtl/ivm_defines.svh
// Constants for the interrupt vector mapper: offsets, fields, source numbers.
// Assumes inclusion by bare name from the design files.
`ifndef IVM_DEFINES_SVH
`define IVM_DEFINES_SVH
`define IVM_NSRC          21
`define IVM_NVEC          32
`define IVM_OFF_FLAGS     12'h000
`define IVM_OFF_ENABLE    12'h004
`define IVM_OFF_GLOBAL    12'h008
`define IVM_OFF_REQ       12'h00c
`define IVM_OFF_FORCE     12'h010
`define IVM_GLOBAL_BIT    0
`define IVM_FLAGS_RST     22'h000000
`define IVM_ENABLE_RST    22'h000000
`define IVM_GLOBAL_RST    1'b0
`define IVM_SRC_NMI       0
`define IVM_SRC_VLM       1
`define IVM_SRC_PA        2
`define IVM_SRC_PB        3
`define IVM_SRC_RTCC      4
`define IVM_SRC_PIT       5
`define IVM_SRC_TAOV      6
`define IVM_SRC_TAHU      7
`define IVM_SRC_CMP0      8
`define IVM_SRC_CMP1      9
`define IVM_SRC_CMP2      10
`define IVM_SRC_TB        11
`define IVM_SRC_AC        12
`define IVM_SRC_RDY       13
`define IVM_SRC_WIN       14
`define IVM_SRC_TWS       15
`define IVM_SRC_TWM       16
`define IVM_SRC_SPI       17
`define IVM_SRC_RX        18
`define IVM_SRC_DRE       19
`define IVM_SRC_TX        20
`define IVM_SRC_EE        21
`endif

// ===== rtl/ivm_pkg.sv
// Types for the interrupt vector mapper.
// Assumes ivm_defines.svh for widths.
`include "ivm_defines.svh"
package ivm_pkg;
  typedef logic [`IVM_NSRC:0]   ivm_src_t;
  typedef logic [`IVM_NVEC-1:0] ivm_vec_t;
  typedef logic [31:0]          ivm_word_t;
endpackage

// ===== rtl/ivm_top.sv
// Interrupt vector mapper: source flags, enables, global gate, APB regs.
// Assumes peripherals pulse src_event; CPU samples vec_req each clock.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "ivm_defines.svh"
module ivm_top
  import ivm_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire ivm_pkg::ivm_word_t pwdata,
  output ivm_pkg::ivm_word_t     prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire ivm_pkg::ivm_src_t src_event,
  output ivm_pkg::ivm_vec_t      vec_req
);
  import ivm_pkg::*;

  ivm_src_t source_pending_flag_r;
  ivm_src_t source_enable_bit_r;
  logic     global_enable_r;
  ivm_src_t src_req;
  ivm_vec_t vec_map;
  logic     wr_en;
  logic     rd_en;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, `IVM_OFF_FLAGS) | hit(a, `IVM_OFF_ENABLE) |
             hit(a, `IVM_OFF_GLOBAL) | hit(a, `IVM_OFF_REQ) |
             hit(a, `IVM_OFF_FORCE);
  endfunction

  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign pslverr = psel & penable & ~mapped(paddr);

  // Flags: event set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      source_pending_flag_r <= `IVM_FLAGS_RST;
    else
    begin
      source_pending_flag_r <= (source_pending_flag_r
        & ~((wr_en && hit(paddr, `IVM_OFF_FLAGS)) ?
            pwdata[`IVM_NSRC:0] : '0))
        | src_event
        | ((wr_en && hit(paddr, `IVM_OFF_FORCE)) ?
            pwdata[`IVM_NSRC:0] : '0);
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      source_enable_bit_r <= `IVM_ENABLE_RST;
    else if (wr_en && hit(paddr, `IVM_OFF_ENABLE))
      source_enable_bit_r <= pwdata[`IVM_NSRC:0];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      global_enable_r <= `IVM_GLOBAL_RST;
    else if (wr_en && hit(paddr, `IVM_OFF_GLOBAL))
      global_enable_r <= pwdata[`IVM_GLOBAL_BIT];

  // Gating: flag and enable and global
  assign src_req = source_pending_flag_r & source_enable_bit_r
                   & {(`IVM_NSRC+1){global_enable_r}};

  ivm_vector_map u_map
  (
    .req (src_req),
    .vec (vec_map)
  );

  // Registered vector outputs; one register covers all vectors
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      vec_req <= '0;
    else
      vec_req <= vec_map;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= '0;
    else if (rd_en)
    begin
      prdata <= '0;
      if (hit(paddr, `IVM_OFF_FLAGS))
        prdata[`IVM_NSRC:0] <= source_pending_flag_r;
      else if (hit(paddr, `IVM_OFF_ENABLE))
        prdata[`IVM_NSRC:0] <= source_enable_bit_r;
      else if (hit(paddr, `IVM_OFF_GLOBAL))
        prdata[`IVM_GLOBAL_BIT] <= global_enable_r;
      else if (hit(paddr, `IVM_OFF_REQ))
        prdata[`IVM_NSRC:0] <= src_req;
    end

  // Assertions
  AST_SET: assert property (@(posedge pclk) disable iff (!presetn)
    src_event[`IVM_SRC_PA] |=> source_pending_flag_r[`IVM_SRC_PA])
    else $error("flag not set by event");
  AST_EN: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, `IVM_OFF_ENABLE) |=>
    source_enable_bit_r == $past(pwdata[`IVM_NSRC:0]))
    else $error("enable write lost");
  AST_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[3] |-> $past(source_pending_flag_r[`IVM_SRC_PA]
      & source_enable_bit_r[`IVM_SRC_PA]))
    else $error("request without flag and enable");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[27] && $past(source_pending_flag_r[`IVM_SRC_RX]
      & source_enable_bit_r[`IVM_SRC_RX] & global_enable_r)
    && source_pending_flag_r[`IVM_SRC_RX] && source_enable_bit_r[`IVM_SRC_RX]
    && global_enable_r |=> vec_req[27])
    else $error("request dropped while flag set");
  AST_GLOBAL: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(global_enable_r) |-> vec_req == '0)
    else $error("request without global enable");
  AST_UNUSED: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[0] == 1'b0 && vec_req[5] == 1'b0 && vec_req[16:14] == '0
    && vec_req[19:18] == '0 && vec_req[23:22] == '0
    && vec_req[31] == 1'b0)
    else $error("unassigned vector requested");
  AST_NMI: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[1] == $past(src_req[`IVM_SRC_NMI]))
    else $error("vector 1 mismatch");
  AST_PIT: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[7] == $past(src_req[`IVM_SRC_PIT]))
    else $error("vector 7 mismatch");
  AST_TB: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[13] == $past(src_req[`IVM_SRC_TB]))
    else $error("vector 13 mismatch");
  AST_EE: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[30] == $past(src_req[`IVM_SRC_EE]))
    else $error("vector 30 mismatch");
  AST_VLM: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[2] == $past(src_req[`IVM_SRC_VLM]))
    else $error("vector 2 mismatch");
  AST_PA: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[3] == $past(src_req[`IVM_SRC_PA]))
    else $error("vector 3 mismatch");
  AST_PB: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[4] == $past(src_req[`IVM_SRC_PB]))
    else $error("vector 4 mismatch");
  AST_RTCC: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[6] == $past(src_req[`IVM_SRC_RTCC]))
    else $error("vector 6 mismatch");
  AST_TAOV: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[8] == $past(src_req[`IVM_SRC_TAOV]))
    else $error("vector 8 mismatch");
  AST_TAHU: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[9] == $past(src_req[`IVM_SRC_TAHU]))
    else $error("vector 9 mismatch");
  AST_CMP0: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[10] == $past(src_req[`IVM_SRC_CMP0]))
    else $error("vector 10 mismatch");
  AST_CMP1: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[11] == $past(src_req[`IVM_SRC_CMP1]))
    else $error("vector 11 mismatch");
  AST_CMP2: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[12] == $past(src_req[`IVM_SRC_CMP2]))
    else $error("vector 12 mismatch");
  AST_AC: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[17] == $past(src_req[`IVM_SRC_AC]))
    else $error("vector 17 mismatch");
  AST_RDY: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[20] == $past(src_req[`IVM_SRC_RDY]))
    else $error("vector 20 mismatch");
  AST_WIN: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[21] == $past(src_req[`IVM_SRC_WIN]))
    else $error("vector 21 mismatch");
  AST_TWS: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[24] == $past(src_req[`IVM_SRC_TWS]))
    else $error("vector 24 mismatch");
  AST_TWM: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[25] == $past(src_req[`IVM_SRC_TWM]))
    else $error("vector 25 mismatch");
  AST_SPI: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[26] == $past(src_req[`IVM_SRC_SPI]))
    else $error("vector 26 mismatch");
  AST_RX: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[27] == $past(src_req[`IVM_SRC_RX]))
    else $error("vector 27 mismatch");
  AST_DRE: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[28] == $past(src_req[`IVM_SRC_DRE]))
    else $error("vector 28 mismatch");
  AST_TX: assert property (@(posedge pclk) disable iff (!presetn)
    vec_req[29] == $past(src_req[`IVM_SRC_TX]))
    else $error("vector 29 mismatch");

  COV_REQ: cover property (@(posedge pclk) disable iff (!presetn)
    vec_req[27]);
  COV_CLR: cover property (@(posedge pclk) disable iff (!presetn)
    vec_req[3] ##1 !vec_req[3]);
  COV_RACE: cover property (@(posedge pclk) disable iff (!presetn)
    src_event[0] && wr_en && hit(paddr, `IVM_OFF_FLAGS) && pwdata[0]);
  COV_EE: cover property (@(posedge pclk) disable iff (!presetn)
    vec_req[30]);
  COV_GATED: cover property (@(posedge pclk) disable iff (!presetn)
    |source_pending_flag_r && !global_enable_r);
endmodule

// ===== rtl/ivm_vector_map.sv
// Fixed routing of source requests onto vector numbers.
// Assumes gated requests from the main block; purely combinational.
`timescale 1ns/100ps
`include "ivm_defines.svh"
module ivm_vector_map
  import ivm_pkg::*;
(
  input  wire ivm_pkg::ivm_src_t req,
  output ivm_pkg::ivm_vec_t       vec
);
  always_comb
  begin
    vec     = '0;
    vec[1]  = req[`IVM_SRC_NMI];
    vec[2]  = req[`IVM_SRC_VLM];
    vec[3]  = req[`IVM_SRC_PA];
    vec[4]  = req[`IVM_SRC_PB];
    vec[6]  = req[`IVM_SRC_RTCC];
    vec[7]  = req[`IVM_SRC_PIT];
    vec[8]  = req[`IVM_SRC_TAOV];
    vec[9]  = req[`IVM_SRC_TAHU];
    vec[10] = req[`IVM_SRC_CMP0];
    vec[11] = req[`IVM_SRC_CMP1];
    vec[12] = req[`IVM_SRC_CMP2];
    vec[13] = req[`IVM_SRC_TB];
    vec[17] = req[`IVM_SRC_AC];
    vec[20] = req[`IVM_SRC_RDY];
    vec[21] = req[`IVM_SRC_WIN];
    vec[24] = req[`IVM_SRC_TWS];
    vec[25] = req[`IVM_SRC_TWM];
    vec[26] = req[`IVM_SRC_SPI];
    vec[27] = req[`IVM_SRC_RX];
    vec[28] = req[`IVM_SRC_DRE];
    vec[29] = req[`IVM_SRC_TX];
    vec[30] = req[`IVM_SRC_EE];
  end
endmodule

// ===== test/interrupt_vector_mapper_tb.sv
// Self-checking bench for the interrupt vector mapper.
// Assumes ivm_top with zero-wait APB and the CPU core model.
`timescale 1ns/100ps
`include "ivm_defines.svh"
module interrupt_vector_mapper_tb;
  import ivm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, look;
  logic        pready, pslverr, irq_seen;
  logic [11:0] paddr;
  ivm_word_t   pwdata, prdata, r;
  ivm_src_t    src_event;
  ivm_vec_t    vec_req, ve;
  logic [32:0] rq[$];
  ivm_vec_t    vq[$];
  int          err_total, cmp_count, cyc, s;
  int vtab[22] = '{1,2,3,4,6,7,8,9,10,11,12,13,17,20,21,24,25,26,27,28,29,
                   30};
  ivm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_event(src_event), .vec_req(vec_req));
  ivm_cpu_model cpu (.pclk(pclk), .presetn(presetn), .vec_req(vec_req),
    .irq_seen(irq_seen));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  function automatic ivm_vec_t vmask(ivm_word_t f);
    ivm_vec_t v;
    v = '0;
    for (int i = 0; i < 22; i++)
      if (f[i])
        v[vtab[i]] = 1'b1;
    return v;
  endfunction
  task automatic chk(string n, logic [32:0] seen, logic [32:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, ivm_word_t d, logic [32:0] e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    if (!w)
      rq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic vchk(ivm_vec_t e);
    repeat (3) @(posedge pclk);
    vq.push_back(e);
    look <= 1'b1;
    @(posedge pclk);
    look <= 1'b0;
  endtask
  task automatic ev(int i);
    @(posedge pclk);
    src_event <= ivm_src_t'(1) << i;
    @(posedge pclk);
    src_event <= '0;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Monitor: reads and vector samples against the oldest note
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite)
      chk("read", {pslverr, prdata}, rq.pop_front());
    if (look)
    begin
      ve = vq.pop_front();
      chk("vec_req", {1'b0, vec_req}, {1'b0, ve});
      chk("irq_seen", irq_seen, |ve);
    end
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  initial
  begin
    {psel, penable, pwrite, look} = '0;
    paddr = '0;
    pwdata = '0;
    src_event = '0;
    presetn = 1'b0;
    void'($urandom(37));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0, 33'h0);
    apb(0, 12'h004, 0, 33'h0);
    apb(0, 12'h008, 0, 33'h0);
    apb(0, 12'h014, 0, 33'h100000000);
    $display("test reset and unmapped done");
    apb(1, 12'h004, 32'h3fffff, 0);
    apb(1, 12'h008, 32'h1, 0);
    for (int i = 0; i < 22; i++)
    begin
      ev(i);
      vchk(vmask(32'h1 << i));
      apb(0, 12'h000, 0, 33'h1 << i);
      vchk(vmask(32'h1 << i));
      apb(1, 12'h000, 32'h1 << i, 0);
      vchk(0);
    end
    $display("test vector map done");
    s = $urandom_range(21, 0);
    apb(1, 12'h004, 32'h3fffff ^ (32'h1 << s), 0);
    ev(s);
    vchk(0);
    apb(0, 12'h000, 0, 33'h1 << s);
    apb(1, 12'h004, 32'h3fffff, 0);
    vchk(vmask(32'h1 << s));
    apb(1, 12'h000, 32'h3fffff, 0);
    $display("test enable gating done");
    r = $urandom & 32'h3fffff;
    apb(1, 12'h008, 0, 0);
    apb(1, 12'h010, r, 0);
    apb(0, 12'h000, 0, {1'b0, r});
    vchk(0);
    apb(1, 12'h008, 1, 0);
    vchk(vmask(r));
    $display("test global gate done");
    report_and_stop();
  end
endmodule

// ===== test/ivm_cpu_model.sv
// CPU core model: takes the vector request levels each clock.
// Assumes vec_req is a registered level from the mapper.
`timescale 1ns/100ps
module ivm_cpu_model
  import ivm_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire ivm_pkg::ivm_vec_t vec_req,
  output logic                   irq_seen
);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      irq_seen <= 1'b0;
    else
      irq_seen <= |vec_req;
endmodule
